// >>> dtpm_defines.svh
`ifndef DTPM_DEFINES_SVH
`define DTPM_DEFINES_SVH

// Register byte offsets
`define DTPM_OFF_CNT1   8'h00
`define DTPM_OFF_CNT2   8'h04
`define DTPM_OFF_RELA   8'h08
`define DTPM_OFF_RELB   8'h0c
`define DTPM_OFF_PRSC   8'h10
`define DTPM_OFF_CLKC   8'h14
`define DTPM_OFF_MODE   8'h18
`define DTPM_OFF_IEN    8'h1c
`define DTPM_OFF_PEND   8'h20
`define DTPM_OFF_ICLR   8'h24

// Field positions
`define DTPM_SEL1_LSB   0
`define DTPM_SEL2_LSB   2
`define DTPM_MODE_LSB   0
`define DTPM_TOG_BIT    2
`define DTPM_INIT_BIT   3
`define DTPM_PND_A      0
`define DTPM_PND_B      1
`define DTPM_PND_C      2
`define DTPM_PND_D      3

// Reset value and counting constants
`define DTPM_RST_ALL    '0
`define DTPM_CAP_PRESET 16'hffff
`define DTPM_CNT_ONE    16'h0001
`define DTPM_DIV_ONE    5'h01

`endif

// >>> dtpm_pkg.sv
package dtpm_pkg;

   // Counter clock source choices
   typedef enum logic [1:0] {src_off, src_presc, src_slow} dtpm_src_type;

   // Operating modes
   typedef enum logic [1:0] {mode_pwm, mode_capture, mode_dual}
      dtpm_mode_type;

   // State of the clock source module
   typedef struct packed {
      logic [4:0] pcnt;
      logic       presc_tick;
      logic [1:0] sync;
      logic       prev;
      logic       slow_tick;
   } dtpm_clk_state_type;

   // State of the timer top
   typedef struct packed {
      logic [15:0]   cnt1;
      logic [15:0]   cnt2;
      logic [15:0]   rel_a;
      logic [15:0]   rel_b;
      logic [4:0]    div;
      dtpm_src_type  sel1;
      dtpm_src_type  sel2;
      dtpm_mode_type mode;
      logic          tog_en;
      logic          init_lvl;
      logic [3:0]    ien;
      logic [3:0]    pend;
      logic          next_b;
      logic          pin;
      logic          pin_oe;
      logic [1:0]    pin_sync;
      logic          pin_prev;
      logic          wr_pend;
      logic [7:0]    wr_addr;
      logic [31:0]   rdata;
      logic          ready;
      logic          resp;
      logic          irq1;
      logic          irq2;
   } dtpm_state_type;

endpackage : dtpm_pkg

// >>> dtpm_clk_src.sv
`timescale 1ns/1ps
`include "dtpm_defines.svh"

module dtpm_clk_src (
   input  wire logic       ref_clk_i,
   input  wire logic       srst_i,
   input  wire logic [4:0] div_i,
   input  wire logic       slow_clk_i,
   output logic            presc_tick_o,
   output logic            slow_tick_o
);

   dtpm_pkg::dtpm_clk_state_type q_q;
   dtpm_pkg::dtpm_clk_state_type q_d;

   // Prescaler and slow clock synchroniser
   always_comb begin
      q_d = q_q;
      if (q_q.pcnt == 5'h00) begin
         q_d.pcnt       = div_i;
         q_d.presc_tick = 1'b1;
      end else begin
         q_d.pcnt       = q_q.pcnt - `DTPM_DIV_ONE;
         q_d.presc_tick = 1'b0;
      end
      q_d.sync      = {q_q.sync[0], slow_clk_i};
      q_d.prev      = q_q.sync[1];
      q_d.slow_tick = q_q.sync[1] & ~q_q.prev;
   end

   // State register
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         q_q <= `DTPM_RST_ALL;
      end else begin
         q_q <= q_d;
      end
   end

   assign presc_tick_o = q_q.presc_tick;
   assign slow_tick_o  = q_q.slow_tick;

   a_presc_gap: assert property (
      @(posedge ref_clk_i) disable iff (srst_i)
      presc_tick_o && div_i != 5'h00 && $stable(div_i)
      |=> !presc_tick_o)
      else $error("prescaler ticked twice with divisor above zero");

   a_presc_unity: assert property (
      @(posedge ref_clk_i) disable iff (srst_i)
      presc_tick_o && $past(div_i) == 5'h00 |=> presc_tick_o)
      else $error("prescaler did not tick every cycle at divisor zero");

   a_presc_clear: assert property (
      @(posedge ref_clk_i) srst_i |=> q_q.pcnt == 5'h00 && !presc_tick_o)
      else $error("prescaler counter not cleared by reset");

   a_slow_gap: assert property (
      @(posedge ref_clk_i) disable iff (srst_i)
      slow_tick_o |=> !slow_tick_o [*2])
      else $error("slow clock ticks closer than three cycles");

endmodule : dtpm_clk_src

// >>> dtpm_timer.sv
// Register access over AHB-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "dtpm_defines.svh"

// Functional notes
// - Two 16-bit down counters plus two 16-bit reload or capture registers.
// - Each counter picks off, prescaled system clock, or slow clock.
// - Prescaler: 5-bit divisor and down counter, divides by divisor plus one.
// - Reset clears prescale divisor and prescaler down counter.
// - Slow clock is synchronised to the system clock before counting.
// - Stopped system clock simply freezes both counters.
// - After reset both timers are off until software configures them.
// - Three modes: PWM, input capture, dual independent timer.
// - PWM: counter one reloads alternately from A then B on underflow.
// - Any stop and restart makes the next reload come from A.
// - When enabled, pin toggles on every counter one underflow outside capture mode.
// - Reload A and reload B interrupts each have their own enable.
// - Each counter one reload from A or B sets its pending flag.
// - Counter two counts down on its own selected clock.
// - Counter two underflow raises interrupt when its enable is set.
// - Sources A, B, C share line one; D drives line two.
// - With toggling enabled, pin starts at the initial-level bit.
module dtpm_timer (
   input  wire logic        ref_clk_i,
   input  wire logic        srst_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   input  wire logic        slow_clk_i,
   input  wire logic        timer_io_pin_i,
   output logic             timer_io_pin_o,
   output logic             timer_io_pin_oe_o,
   output logic             timer_irq1_o,
   output logic             timer_irq2_o
);

   dtpm_pkg::dtpm_state_type q_q;
   dtpm_pkg::dtpm_state_type q_d;
   logic                     presc_tick;
   logic                     slow_tick;
   logic                     tick1;
   logic                     tick2;
   logic                     uf1;
   logic                     uf2;
   logic                     pin_rise;
   logic                     wr_cnt1;
   logic                     wr_cnt2;
   logic [31:0]              wd;

   // Selected source to a counting tick
   function automatic logic src_tick(input dtpm_pkg::dtpm_src_type s,
                                     input logic p,
                                     input logic w);
      logic t;
      t = 1'b0;
      unique case (s)
         dtpm_pkg::src_off:   t = 1'b0;
         dtpm_pkg::src_presc: t = p;
         dtpm_pkg::src_slow:  t = w;
      endcase
      return t;
   endfunction : src_tick

   // Written selector code to source, unused code means off
   function automatic dtpm_pkg::dtpm_src_type decode_src(
      input logic [1:0] v);
      dtpm_pkg::dtpm_src_type s;
      s = dtpm_pkg::src_off;
      unique case (v)
         2'h1:    s = dtpm_pkg::src_presc;
         2'h2:    s = dtpm_pkg::src_slow;
         default: s = dtpm_pkg::src_off;
      endcase
      return s;
   endfunction : decode_src

   // Written mode code to mode, unused code falls back to PWM
   function automatic dtpm_pkg::dtpm_mode_type decode_mode(
      input logic [1:0] v);
      dtpm_pkg::dtpm_mode_type m;
      m = dtpm_pkg::mode_pwm;
      unique case (v)
         2'h1:    m = dtpm_pkg::mode_capture;
         2'h2:    m = dtpm_pkg::mode_dual;
         default: m = dtpm_pkg::mode_pwm;
      endcase
      return m;
   endfunction : decode_mode

   // Register read mux, unmapped offsets read zero
   function automatic logic [31:0] rd_word(input logic [7:0] a,
      input dtpm_pkg::dtpm_state_type s);
      logic [31:0] r;
      r = 32'h0000_0000;
      case (a)
         `DTPM_OFF_CNT1: r[15:0] = s.cnt1;
         `DTPM_OFF_CNT2: r[15:0] = s.cnt2;
         `DTPM_OFF_RELA: r[15:0] = s.rel_a;
         `DTPM_OFF_RELB: r[15:0] = s.rel_b;
         `DTPM_OFF_PRSC: r[4:0]  = s.div;
         `DTPM_OFF_CLKC: begin
            r[`DTPM_SEL1_LSB +: 2] = s.sel1;
            r[`DTPM_SEL2_LSB +: 2] = s.sel2;
         end
         `DTPM_OFF_MODE: begin
            r[`DTPM_MODE_LSB +: 2] = s.mode;
            r[`DTPM_TOG_BIT]       = s.tog_en;
            r[`DTPM_INIT_BIT]      = s.init_lvl;
         end
         `DTPM_OFF_IEN:  r[3:0] = s.ien;
         `DTPM_OFF_PEND: r[3:0] = s.pend;
         default:        r = 32'h0000_0000;
      endcase
      return r;
   endfunction : rd_word

   // Prescaler and slow clock synchroniser
   dtpm_clk_src u_clk_src (
      .ref_clk_i    (ref_clk_i),
      .srst_i       (srst_i),
      .div_i        (q_q.div),
      .slow_clk_i   (slow_clk_i),
      .presc_tick_o (presc_tick),
      .slow_tick_o  (slow_tick)
   );

   // Ticks, underflows and pending bus writes
   always_comb begin
      tick1    = src_tick(q_q.sel1, presc_tick, slow_tick);
      tick2    = src_tick(q_q.sel2, presc_tick, slow_tick);
      uf1      = tick1 && q_q.cnt1 == 16'h0000;
      uf2      = tick2 && q_q.cnt2 == 16'h0000;
      pin_rise = q_q.pin_sync[1] & ~q_q.pin_prev;
      wr_cnt1  = q_q.wr_pend && q_q.wr_addr == `DTPM_OFF_CNT1;
      wr_cnt2  = q_q.wr_pend && q_q.wr_addr == `DTPM_OFF_CNT2;
      wd       = hwdata_i;
   end

   // Next state of the whole timer
   always_comb begin
      q_d = q_q;
      // Timer pin input synchroniser
      q_d.pin_sync = {q_q.pin_sync[0], timer_io_pin_i};
      q_d.pin_prev = q_q.pin_sync[1];
      // Software clear first so a same-cycle event still sets its flag
      if (q_q.wr_pend && q_q.wr_addr == `DTPM_OFF_ICLR) begin
         q_d.pend = q_q.pend & ~wd[3:0];
      end
      // Counter one, a clock off leaves it frozen
      if (uf1) begin
         unique case (q_q.mode)
            dtpm_pkg::mode_pwm: begin
               q_d.cnt1   = q_q.next_b ? q_q.rel_b : q_q.rel_a;
               q_d.next_b = ~q_q.next_b;
               if (q_q.next_b) begin
                  q_d.pend[`DTPM_PND_B] = 1'b1;
               end else begin
                  q_d.pend[`DTPM_PND_A] = 1'b1;
               end
            end
            dtpm_pkg::mode_capture: begin
               q_d.cnt1              = `DTPM_CAP_PRESET;
               q_d.pend[`DTPM_PND_C] = 1'b1;
            end
            dtpm_pkg::mode_dual: begin
               q_d.cnt1              = q_q.rel_a;
               q_d.pend[`DTPM_PND_A] = 1'b1;
            end
         endcase
      end else if (tick1) begin
         q_d.cnt1 = q_q.cnt1 - `DTPM_CNT_ONE;
      end
      // Capture of counter one on a rising pin edge
      if (q_q.mode == dtpm_pkg::mode_capture && pin_rise) begin
         q_d.rel_a             = q_q.cnt1;
         q_d.pend[`DTPM_PND_A] = 1'b1;
         if (q_q.tog_en) begin
            q_d.cnt1 = `DTPM_CAP_PRESET;
         end
      end
      // Stopped or outside PWM: next reload comes from A
      if (q_q.sel1 == dtpm_pkg::src_off ||
          q_q.mode != dtpm_pkg::mode_pwm) begin
         q_d.next_b = 1'b0;
      end
      // Counter two, general timer reloading from B
      if (uf2) begin
         q_d.cnt2              = q_q.rel_b;
         q_d.pend[`DTPM_PND_D] = 1'b1;
      end else if (tick2) begin
         q_d.cnt2 = q_q.cnt2 - `DTPM_CNT_ONE;
      end
      // Timer pin: rest level while stopped, toggle on underflow outside capture mode
      if (!q_q.tog_en || q_q.sel1 == dtpm_pkg::src_off) begin
         q_d.pin = q_q.init_lvl;
      end else if (uf1 && q_q.mode != dtpm_pkg::mode_capture) begin
         q_d.pin = ~q_q.pin;
      end
      q_d.pin_oe = q_q.tog_en && q_q.mode != dtpm_pkg::mode_capture;
      // Bus write data phase, software write beats the counter
      if (q_q.wr_pend) begin
         case (q_q.wr_addr)
            `DTPM_OFF_CNT1: q_d.cnt1  = wd[15:0];
            `DTPM_OFF_CNT2: q_d.cnt2  = wd[15:0];
            `DTPM_OFF_RELA: q_d.rel_a = wd[15:0];
            `DTPM_OFF_RELB: q_d.rel_b = wd[15:0];
            `DTPM_OFF_PRSC: q_d.div   = wd[4:0];
            `DTPM_OFF_CLKC: begin
               q_d.sel1 = decode_src(wd[`DTPM_SEL1_LSB +: 2]);
               q_d.sel2 = decode_src(wd[`DTPM_SEL2_LSB +: 2]);
            end
            `DTPM_OFF_MODE: begin
               q_d.mode     = decode_mode(wd[`DTPM_MODE_LSB +: 2]);
               q_d.tog_en   = wd[`DTPM_TOG_BIT];
               q_d.init_lvl = wd[`DTPM_INIT_BIT];
            end
            `DTPM_OFF_IEN:  q_d.ien = wd[3:0];
            default: ;
         endcase
      end
      // Bus address phase
      q_d.wr_pend = 1'b0;
      if (hsel_i && hready_i && htrans_i[1]) begin
         q_d.wr_pend = hwrite_i;
         q_d.wr_addr = haddr_i[7:0];
         if (!hwrite_i) begin
            q_d.rdata = rd_word(haddr_i[7:0], q_q);
         end
      end
      q_d.ready = 1'b1;
      q_d.resp  = 1'b0;
      // Interrupt lines from enabled pending sources
      q_d.irq1 = |(q_d.pend[2:0] & q_d.ien[2:0]);
      q_d.irq2 = q_d.pend[`DTPM_PND_D] & q_d.ien[`DTPM_PND_D];
   end

   // State register; all selectors off after reset
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         q_q <= `DTPM_RST_ALL;
      end else begin
         q_q <= q_d;
      end
   end

   // Outputs straight from the state register
   assign hrdata_o          = q_q.rdata;
   assign hreadyout_o       = q_q.ready;
   assign hresp_o           = q_q.resp;
   assign timer_io_pin_o    = q_q.pin;
   assign timer_io_pin_oe_o = q_q.pin_oe;
   assign timer_irq1_o      = q_q.irq1;
   assign timer_irq2_o      = q_q.irq2;

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (srst_i);

   a_reset_off: assert property (
      @(posedge ref_clk_i) disable iff (1'b0)
      srst_i |=> q_q.sel1 == dtpm_pkg::src_off &&
                 q_q.sel2 == dtpm_pkg::src_off && !timer_irq1_o)
      else $error("timer not disabled after reset");

   a_stop_hold: assert property (
      q_q.sel1 == dtpm_pkg::src_off && !wr_cnt1 &&
      q_q.mode != dtpm_pkg::mode_capture
      |=> q_q.cnt1 == $past(q_q.cnt1))
      else $error("counter one moved with its clock off");

   a_reload_alt: assert property (
      uf1 && q_q.mode == dtpm_pkg::mode_pwm && !q_q.next_b && !wr_cnt1
      |=> q_q.cnt1 == $past(q_q.rel_a) && q_q.next_b)
      else $error("first PWM reload not from register A");

   a_pend_b_set: assert property (
      uf1 && q_q.mode == dtpm_pkg::mode_pwm && q_q.next_b
      |=> q_q.pend[`DTPM_PND_B] && !q_q.next_b)
      else $error("reload from B did not set its pending flag");

   a_first_from_a: assert property (
      q_q.sel1 == dtpm_pkg::src_off |=> !q_q.next_b)
      else $error("restart would not reload from A");

   a_pin_toggle: assert property (
      uf1 && q_q.tog_en && q_q.mode != dtpm_pkg::mode_capture
      |=> timer_io_pin_o != $past(timer_io_pin_o))
      else $error("pin did not toggle on underflow");

   a_pin_init: assert property (
      !q_q.tog_en |=> timer_io_pin_o == $past(q_q.init_lvl))
      else $error("pin not at initial level while toggling off");

   a_cnt2_reload: assert property (
      uf2 && !wr_cnt2 |=> q_q.cnt2 == $past(q_q.rel_b))
      else $error("counter two did not reload on underflow");

   a_irq2_raise: assert property (
      uf2 && q_q.ien[`DTPM_PND_D] &&
      !(q_q.wr_pend && q_q.wr_addr == `DTPM_OFF_IEN)
      |=> timer_irq2_o)
      else $error("counter two underflow gave no interrupt");

   a_irq1_merge: assert property (
      (q_q.pend[2:0] & q_q.ien[2:0]) != 3'h0 |-> timer_irq1_o)
      else $error("enabled source A, B or C missing on line one");

   a_pwm_entry: assert property (
      q_q.mode != dtpm_pkg::mode_pwm |=> !q_q.next_b)
      else $error("leaving PWM did not rearm the reload from A");

   a_pend_a_set: assert property (
      uf1 && q_q.mode == dtpm_pkg::mode_pwm && !q_q.next_b
      |=> q_q.pend[`DTPM_PND_A])
      else $error("reload from A did not set its pending flag");

   a_count_step: assert property (
      tick1 && q_q.cnt1 != 16'h0000 && !wr_cnt1 &&
      !(q_q.mode == dtpm_pkg::mode_capture && pin_rise)
      |=> q_q.cnt1 == $past(q_q.cnt1) - `DTPM_CNT_ONE)
      else $error("counter one tick did not count down by one");

   a_cnt2_step: assert property (
      tick2 && q_q.cnt2 != 16'h0000 && !wr_cnt2
      |=> q_q.cnt2 == $past(q_q.cnt2) - `DTPM_CNT_ONE)
      else $error("counter two tick did not count down by one");

   a_pend_d_set: assert property (
      uf2 |=> q_q.pend[`DTPM_PND_D])
      else $error("counter two underflow did not set its pending flag");

   a_pin_hold: assert property (
      q_q.tog_en && q_q.sel1 != dtpm_pkg::src_off && !uf1
      |=> timer_io_pin_o == $past(timer_io_pin_o))
      else $error("pin moved without an underflow");

endmodule : dtpm_timer

// >>> dtpm_pin_load.sv
`timescale 1ns/1ps

// Far side of the timer: slow clock source and a pulled-down pin load
module dtpm_pin_load (
   input  wire logic pin_o_i,
   input  wire logic pin_oe_i,
   output logic      slow_clk_o,
   output logic      pin_level_o
);
   // Slow clock at one eighth of the system rate, phase unrelated
   // The system clock never runs from it here
   initial begin
      slow_clk_o = 1'h0;
      #7;
      forever #20 slow_clk_o = ~slow_clk_o;
   end

   // Wire level: the timer drives it when enabled, else pulled low
   assign pin_level_o = pin_oe_i ? pin_o_i : 1'h0;
endmodule : dtpm_pin_load

// >>> testbench.sv
`timescale 1ns/1ps
`include "dtpm_defines.svh"

module testbench;
   logic        clk    = 1'h0;
   logic        srst   = 1'h1;
   logic        hsel   = 1'h0;
   logic [31:0] haddr  = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'h0;
   logic [2:0]  hsize  = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hready;
   logic        hresp;
   logic        slow_clk;
   logic        pin_i;
   logic        pin_o;
   logic        pin_oe;
   logic        irq1;
   logic        irq2;
   logic [31:0] rd;
   logic [31:0] r1;
   int          bad_count = 0;
   int          n_checks  = 0;
   int          n;
   int          exp_d[4]  = '{0, 16, 8, 0};

   // System clock, 5 ns period
   always #2.5 clk = ~clk;

   dtpm_timer dtpm_timer_i (
      .ref_clk_i(clk), .srst_i(srst), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
      .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
      .hreadyout_o(hready), .hresp_o(hresp), .slow_clk_i(slow_clk),
      .timer_io_pin_i(pin_i), .timer_io_pin_o(pin_o),
      .timer_io_pin_oe_o(pin_oe), .timer_irq1_o(irq1),
      .timer_irq2_o(irq2));

   dtpm_pin_load dtpm_pin_load_i (
      .pin_o_i(pin_o), .pin_oe_i(pin_oe), .slow_clk_o(slow_clk),
      .pin_level_o(pin_i));

   // Compare and count
   task check(input logic [31:0] seen, input logic [31:0] exp,
              input string what);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s: seen %h expected %h", $time, what,
                  seen, exp);
      end
   endtask : check

   // One AHB-Lite single word transfer
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel   <= 1'h1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= wr;
      @(posedge clk);
      while (hready !== 1'h1) @(posedge clk);
      htrans <= 2'h0;
      hsel   <= 1'h0;
      hwdata <= wd;
      @(posedge clk);
      while (hready !== 1'h1) @(posedge clk);
      rd = hrdata;
   endtask : bus

   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'h1, a, d);
   endtask : wr

   task rchk(input logic [7:0] a, input logic [31:0] e, input string w);
      bus(1'h0, a, 32'h0);
      check(rd, e, w);
   endtask : rchk

   task cycles(input int c);
      repeat (c) @(posedge clk);
   endtask : cycles

   // Cycles until the pin level changes
   task tog(output int k);
      logic p;
      p = pin_o;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pin_o === p && k < 100);
   endtask : tog

   task conclude;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : conclude

   // Watchdog against a hung handshake
   initial begin
      #100000;
      bad_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      conclude();
   end

   // Main sequence
   initial begin
      cycles(2);
      srst <= 1'h0;
      cycles(1);
      for (int a = 0; a <= 40; a += 4)
         rchk(a[7:0], 32'h0, "reset value");
      check({27'h0, hresp, pin_o, pin_oe, irq1, irq2}, 32'h0,
            "idle");
      wr(`DTPM_OFF_PRSC, 32'hffffffff);
      rchk(`DTPM_OFF_PRSC, 32'h1f, "divisor width");
      wr(8'h28, 32'hffffffff);
      rchk(8'h28, 32'h0, "unmapped");
      $display("test reset done");

      // Selector sweep on counter two, divisor 3
      wr(`DTPM_OFF_PRSC, 32'h3);
      for (int s = 0; s < 4; s++) begin
         wr(`DTPM_OFF_CLKC, {28'h0, s[1:0], 2'h0});
         rchk(`DTPM_OFF_CLKC, {28'h0, (s == 3) ? 2'h0 : s[1:0], 2'h0},
              "selector");
         wr(`DTPM_OFF_CNT2, 32'h100);
         bus(1'h0, `DTPM_OFF_CNT2, 32'h0);
         r1 = rd;
         cycles(62);
         bus(1'h0, `DTPM_OFF_CNT2, 32'h0);
         check(r1 - rd, exp_d[s], "count rate");
      end
      wr(`DTPM_OFF_CLKC, 32'h0);
      $display("test clock sources done");

      // PWM with reload A 6, reload B 9, start high
      wr(`DTPM_OFF_RELA, 32'h6);
      wr(`DTPM_OFF_RELB, 32'h9);
      wr(`DTPM_OFF_CNT1, 32'h0);
      wr(`DTPM_OFF_MODE, 32'hc);
      wr(`DTPM_OFF_PRSC, 32'h0);
      check({30'h0, pin_o, pin_oe}, 32'h3, "initial level");
      wr(`DTPM_OFF_CLKC, 32'h1);
      tog(n);
      tog(n);
      check(n, 32'h7, "width from A");
      tog(n);
      check(n, 32'ha, "width from B");
      wr(`DTPM_OFF_CLKC, 32'h0);
      rchk(`DTPM_OFF_PEND, 32'h3, "pending A and B");
      check({31'h0, irq1}, 32'h0, "masked line one");
      check({31'h0, pin_o}, 32'h1, "stopped level");
      wr(`DTPM_OFF_ICLR, 32'hf);
      rchk(`DTPM_OFF_PEND, 32'h0, "cleared");
      wr(`DTPM_OFF_IEN, 32'h1);
      wr(`DTPM_OFF_CNT1, 32'h0);
      wr(`DTPM_OFF_CLKC, 32'h1);
      cycles(3);
      rchk(`DTPM_OFF_PEND, 32'h1, "first reload");
      check({31'h0, irq1}, 32'h1, "line one");
      wr(`DTPM_OFF_CLKC, 32'h0);
      wr(`DTPM_OFF_ICLR, 32'hf);
      for (int m = 0; m < 3; m++) begin
         wr(`DTPM_OFF_MODE, m | 4);
         rchk(`DTPM_OFF_MODE, m | 4, "mode");
         check({31'h0, pin_oe}, (m != 1), "pin drive");
      end
      wr(`DTPM_OFF_MODE, 32'h0);
      $display("test pwm done");

      // Counter two underflow
      wr(`DTPM_OFF_IEN, 32'h0);
      wr(`DTPM_OFF_CNT2, 32'h1);
      wr(`DTPM_OFF_CLKC, 32'h4);
      cycles(4);
      wr(`DTPM_OFF_CLKC, 32'h0);
      rchk(`DTPM_OFF_PEND, 32'h8, "underflow two");
      check({31'h0, irq2}, 32'h0, "masked line two");
      wr(`DTPM_OFF_IEN, 32'h8);
      cycles(2);
      check({30'h0, irq1, irq2}, 32'h1, "line two");
      wr(`DTPM_OFF_ICLR, 32'h8);
      cycles(2);
      check({31'h0, irq2}, 32'h0, "line two cleared");
      $display("test counter two done");

      // Reset in mid-run
      wr(`DTPM_OFF_PRSC, 32'h5);
      wr(`DTPM_OFF_MODE, 32'h6);
      srst <= 1'h1;
      cycles(2);
      srst <= 1'h0;
      cycles(1);
      rchk(`DTPM_OFF_PRSC, 32'h0, "divisor after reset");
      rchk(`DTPM_OFF_MODE, 32'h0, "mode after reset");
      $display("test second reset done");
      conclude();
   end
endmodule : testbench
